// ===== include/rtcdp_pkg.sv
// Purpose: Constants and helpers for the dual-port time and backup memory.
// Assumes: Counters are held in binary and converted when a port reads or
//          writes them.
// Notes:   Offsets are the byte addresses seen by both access ports.
package rtcdp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCDP_OFS_SEC = 8'h00;
  localparam logic [7:0] RTCDP_OFS_SEC_ALM = 8'h01;
  localparam logic [7:0] RTCDP_OFS_MIN = 8'h02;
  localparam logic [7:0] RTCDP_OFS_MIN_ALM = 8'h03;
  localparam logic [7:0] RTCDP_OFS_HOUR = 8'h04;
  localparam logic [7:0] RTCDP_OFS_HOUR_ALM = 8'h05;
  localparam logic [7:0] RTCDP_OFS_WDAY = 8'h06;
  localparam logic [7:0] RTCDP_OFS_MDAY = 8'h07;
  localparam logic [7:0] RTCDP_OFS_MONTH = 8'h08;
  localparam logic [7:0] RTCDP_OFS_YEAR = 8'h09;
  localparam logic [7:0] RTCDP_OFS_CTRL = 8'h0A;
  localparam logic [7:0] RTCDP_OFS_STAT = 8'h0B;
  localparam logic [7:0] RTCDP_OFS_CTRL2 = 8'h0D;

  // ----------------------------------------------------------------
  // Reset values, as presented in the default data mode
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCDP_RST_SEC = 8'h00;
  localparam logic [7:0] RTCDP_RST_MIN = 8'h00;
  localparam logic [7:0] RTCDP_RST_HOUR = 8'h12;
  localparam logic [7:0] RTCDP_RST_ALM = 8'h00;
  localparam logic [7:0] RTCDP_RST_HOUR_ALM = 8'h12;
  localparam logic [7:0] RTCDP_RST_WDAY = 8'h01;
  localparam logic [7:0] RTCDP_RST_MDAY = 8'h01;
  localparam logic [7:0] RTCDP_RST_MONTH = 8'h01;
  localparam logic [7:0] RTCDP_RST_YEAR = 8'h00;
  localparam logic [7:0] RTCDP_RST_CTRL = 8'h00;
  localparam logic [7:0] RTCDP_RST_STAT = 8'h00;
  localparam logic [7:0] RTCDP_RST_CTRL2 = 8'h00;
  localparam logic [7:0] RTCDP_MEM_CLR_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RTCDP_CTRL_TWO_BIT = 0;
  localparam int RTCDP_CTRL_HF_BIT = 5;
  localparam int RTCDP_CTRL_DM_BIT = 6;
  localparam int RTCDP_CTRL_ST_BIT = 7;
  localparam int RTCDP_CTRL2_MWO_BIT = 0;
  localparam int RTCDP_HOUR_PM_BIT = 7;

  // ----------------------------------------------------------------
  // Counter limits and memory shape
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCDP_SEC_MAX = 8'h3B;
  localparam logic [7:0] RTCDP_HOUR_MAX = 8'h17;
  localparam logic [7:0] RTCDP_HOUR_NOON = 8'h0C;
  localparam logic [7:0] RTCDP_WDAY_MAX = 8'h07;
  localparam logic [7:0] RTCDP_MONTH_MAX = 8'h0C;
  localparam logic [7:0] RTCDP_YEAR_MAX = 8'h63;
  localparam logic [7:0] RTCDP_FEB = 8'h02;
  localparam int RTCDP_MEM_AW = 7;
  localparam int RTCDP_MEM_DEPTH = 128;

  // Binary value 0..99 to two packed decimal digits.
  function automatic logic [7:0] rtcdp_bin2bcd(input logic [7:0] b);
    logic [7:0] t;
    logic [7:0] u;
    t = b / 8'd10;
    u = b % 8'd10;
    return {t[3:0], u[3:0]};
  endfunction

  // Two packed decimal digits to a binary value.
  function automatic logic [7:0] rtcdp_bcd2bin(input logic [7:0] d);
    return 8'({4'h0, d[7:4]} * 8'd10) + {4'h0, d[3:0]};
  endfunction

endpackage

// ===== design/rtcdp_mem.sv
// Purpose: 128-byte backup memory with two registered read ports.
// Assumes: Only one writer at a time; the caller picks the owning port.
// Notes:   A clear request sweeps every byte to zero, one per clock.
`timescale 1ns/1ps
module rtcdp_mem
  import rtcdp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clr_start,
  input wire logic wr_en,
  input wire logic [RTCDP_MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [RTCDP_MEM_AW-1:0] rd_addr_a,
  input wire logic [RTCDP_MEM_AW-1:0] rd_addr_b,
  output logic [7:0] rd_data_a_r,
  output logic [7:0] rd_data_b_r,
  output logic clr_busy_r
);

  logic [7:0] mem [0:RTCDP_MEM_DEPTH-1];
  logic [RTCDP_MEM_AW-1:0] clr_idx_r;
  wire clr_last = (clr_idx_r == {RTCDP_MEM_AW{1'b1}});

  // ----------------------------------------------------------------
  // Clear sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      clr_busy_r <= 1'b0;
      clr_idx_r <= '0;
    end
    else if (clr_start)
    begin
      clr_busy_r <= 1'b1;
      clr_idx_r <= '0;
    end
    else if (clr_busy_r)
    begin
      clr_busy_r <= !clr_last;
      clr_idx_r <= clr_idx_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // clear to zero
  always_ff @(posedge clock)
  begin
    if (clr_busy_r)
      mem[clr_idx_r] <= RTCDP_MEM_CLR_VAL;
    else if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge clock)
  begin
    rd_data_a_r <= mem[rd_addr_a];
    rd_data_b_r <= mem[rd_addr_b];
  end

endmodule

// ===== design/rtcdp_top.sv
// Purpose: Time, calendar and alarm registers plus a 128-byte backup memory
//          shared by a primary and a secondary access port.
// Assumes: The two I2C target engines outside hand over decoded byte
//          accesses as one-cycle strobes on this clock; the one-second tick
//          and the clear pin are asynchronous levels.
// Notes:   Reads answer two cycles after the strobe.
`timescale 1ns/1ps
module rtcdp_top
  import rtcdp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic one_hz_tick,
  input wire logic backup_clear_pin,
  input wire logic p_rtc_wr,
  input wire logic p_rtc_rd,
  input wire logic p_mem_wr,
  input wire logic p_mem_rd,
  input wire logic [7:0] p_addr,
  input wire logic [7:0] p_wdata,
  output logic [7:0] p_rdata_r,
  output logic p_rvalid_r,
  input wire logic s_rtc_wr,
  input wire logic s_rtc_rd,
  input wire logic s_mem_wr,
  input wire logic s_mem_rd,
  input wire logic [7:0] s_addr,
  input wire logic [7:0] s_wdata,
  output logic [7:0] s_rdata_r,
  output logic s_rvalid_r,
  output logic mem_clear_busy_r
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tick_s1_r, tick_s2_r, tick_s3_r;
  logic clr_s1_r, clr_s2_r, clr_s3_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
      clr_s1_r <= 1'b0;
      clr_s2_r <= 1'b0;
      clr_s3_r <= 1'b0;
    end
    else
    begin
      tick_s1_r <= one_hz_tick;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
      clr_s1_r <= backup_clear_pin;
      clr_s2_r <= clr_s1_r;
      clr_s3_r <= clr_s2_r;
    end
  end

  wire tick_rise = tick_s2_r & ~tick_s3_r;
  wire clr_rise = clr_s2_r & ~clr_s3_r;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] sec_r, min_r, hour_r, wday_r, mday_r, month_r, year_r;
  logic [7:0] sec_nxt, min_nxt, hour_nxt, wday_nxt, mday_nxt;
  logic [7:0] month_nxt, year_nxt;
  logic [7:0] sec_alm_r, min_alm_r, hour_alm_r;
  logic [7:0] ctrl_r, stat_r, ctrl2_r;

  wire two = ctrl_r[RTCDP_CTRL_TWO_BIT];
  wire memory_write_owner_sel = ctrl2_r[RTCDP_CTRL2_MWO_BIT];
  wire bin_mode = ctrl_r[RTCDP_CTRL_DM_BIT];
  wire h24_mode = ctrl_r[RTCDP_CTRL_HF_BIT];
  wire stopped = ctrl_r[RTCDP_CTRL_ST_BIT];

  // ----------------------------------------------------------------
  // Write rights decode
  // ----------------------------------------------------------------
  function automatic logic is_time(input logic [7:0] a);
    return (a == RTCDP_OFS_SEC) || (a == RTCDP_OFS_MIN) ||
           (a == RTCDP_OFS_HOUR) ||
           ((a >= RTCDP_OFS_WDAY) && (a <= RTCDP_OFS_YEAR));
  endfunction

  function automatic logic is_alarm(input logic [7:0] a);
    return (a == RTCDP_OFS_SEC_ALM) || (a == RTCDP_OFS_MIN_ALM) ||
           (a == RTCDP_OFS_HOUR_ALM);
  endfunction

  wire p_time_wr = p_rtc_wr & is_time(p_addr) & two;
  wire s_time_wr = s_rtc_wr & is_time(s_addr) & ~two;
  wire time_wr = p_time_wr | s_time_wr;
  wire [7:0] time_wa = p_time_wr ? p_addr : s_addr;
  wire [7:0] time_wd = p_time_wr ? p_wdata : s_wdata;
  wire p_alm_wr = p_rtc_wr & is_alarm(p_addr);
  wire p_ctrl_wr = p_rtc_wr & (p_addr == RTCDP_OFS_CTRL);
  wire p_stat_wr = p_rtc_wr & (p_addr == RTCDP_OFS_STAT);
  wire p_ctrl2_wr = p_rtc_wr & (p_addr == RTCDP_OFS_CTRL2);

  // ----------------------------------------------------------------
  // Value conversion
  // ----------------------------------------------------------------
  // digit fields 0-9
  function automatic logic [7:0] enc(input logic [7:0] v, input logic bm);
    return bm ? v : rtcdp_bin2bcd(v);
  endfunction

  function automatic logic [7:0] dec(input logic [7:0] d, input logic bm);
    return bm ? d : rtcdp_bcd2bin(d);
  endfunction

  wire [7:0] wr_val = dec(time_wd, bin_mode);
  wire [7:0] wr_h12 = dec({1'b0, time_wd[6:0]}, bin_mode);
  wire wr_pm = time_wd[RTCDP_HOUR_PM_BIT];
  wire [7:0] wr_h12_base = (wr_h12 == RTCDP_HOUR_NOON) ? 8'h00 : wr_h12;
  wire [7:0] wr_hour = h24_mode ? wr_val :
                       (wr_pm ? wr_h12_base + RTCDP_HOUR_NOON : wr_h12_base);

  wire hour_pm = (hour_r >= RTCDP_HOUR_NOON);
  wire [7:0] hour_12 = (hour_r == 8'h00) ? RTCDP_HOUR_NOON :
                       (hour_pm && hour_r != RTCDP_HOUR_NOON) ?
                       hour_r - RTCDP_HOUR_NOON : hour_r;
  wire [7:0] hour_enc12 = enc(hour_12, bin_mode);
  wire [7:0] hour_view = h24_mode ? enc(hour_r, bin_mode) :
                         {hour_pm, hour_enc12[6:0]};

  // ----------------------------------------------------------------
  // Calendar advance
  // ----------------------------------------------------------------
  // leap February
  wire leap = (year_r[1:0] == 2'b00);
  logic [7:0] month_days;

  always_comb
  begin
    case (month_r)
      RTCDP_FEB: month_days = leap ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: month_days = 8'h1E;
      default: month_days = 8'h1F;
    endcase
  end

  wire sec_wrap = (sec_r >= RTCDP_SEC_MAX);
  wire min_wrap = sec_wrap && (min_r >= RTCDP_SEC_MAX);
  wire hour_wrap = min_wrap && (hour_r >= RTCDP_HOUR_MAX);
  wire mday_wrap = hour_wrap && (mday_r >= month_days);
  wire month_wrap = mday_wrap && (month_r >= RTCDP_MONTH_MAX);

  always_comb
  begin
    sec_nxt = sec_wrap ? 8'h00 : sec_r + 8'h01;
    min_nxt = min_r;
    hour_nxt = hour_r;
    wday_nxt = wday_r;
    mday_nxt = mday_r;
    month_nxt = month_r;
    year_nxt = year_r;
    if (sec_wrap)
      min_nxt = (min_r >= RTCDP_SEC_MAX) ? 8'h00 : min_r + 8'h01;
    if (min_wrap)
      hour_nxt = (hour_r >= RTCDP_HOUR_MAX) ? 8'h00 : hour_r + 8'h01;
    if (hour_wrap)
    begin
      wday_nxt = (wday_r >= RTCDP_WDAY_MAX) ? 8'h01 : wday_r + 8'h01;
      mday_nxt = mday_wrap ? 8'h01 : mday_r + 8'h01;
    end
    if (mday_wrap)
      month_nxt = month_wrap ? 8'h01 : month_r + 8'h01;
    if (month_wrap)
      year_nxt = (year_r >= RTCDP_YEAR_MAX) ? 8'h00 : year_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // Time and calendar registers
  // ----------------------------------------------------------------
  // one step per tick
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sec_r <= rtcdp_bcd2bin(RTCDP_RST_SEC);
      min_r <= rtcdp_bcd2bin(RTCDP_RST_MIN);
      hour_r <= rtcdp_bcd2bin(RTCDP_RST_HOUR);
      wday_r <= rtcdp_bcd2bin(RTCDP_RST_WDAY);
      mday_r <= rtcdp_bcd2bin(RTCDP_RST_MDAY);
      month_r <= rtcdp_bcd2bin(RTCDP_RST_MONTH);
      year_r <= rtcdp_bcd2bin(RTCDP_RST_YEAR);
    end
    else if (time_wr)
    begin
      case (time_wa)
        RTCDP_OFS_SEC: sec_r <= wr_val;
        RTCDP_OFS_MIN: min_r <= wr_val;
        RTCDP_OFS_HOUR: hour_r <= wr_hour;
        RTCDP_OFS_WDAY: wday_r <= wr_val;
        RTCDP_OFS_MDAY: mday_r <= wr_val;
        RTCDP_OFS_MONTH: month_r <= wr_val;
        default: year_r <= wr_val;
      endcase
    end
    else if (tick_rise && !stopped)
    begin
      sec_r <= sec_nxt;
      min_r <= min_nxt;
      hour_r <= hour_nxt;
      wday_r <= wday_nxt;
      mday_r <= mday_nxt;
      month_r <= month_nxt;
      year_r <= year_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Alarm and control registers
  // ----------------------------------------------------------------
  // owner bits from primary only
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sec_alm_r <= RTCDP_RST_ALM;
      min_alm_r <= RTCDP_RST_ALM;
      hour_alm_r <= RTCDP_RST_HOUR_ALM;
      ctrl_r <= RTCDP_RST_CTRL;
      stat_r <= RTCDP_RST_STAT;
      ctrl2_r <= RTCDP_RST_CTRL2;
    end
    else
    begin
      if (p_alm_wr && p_addr == RTCDP_OFS_SEC_ALM)
        sec_alm_r <= p_wdata;
      if (p_alm_wr && p_addr == RTCDP_OFS_MIN_ALM)
        min_alm_r <= p_wdata;
      if (p_alm_wr && p_addr == RTCDP_OFS_HOUR_ALM)
        hour_alm_r <= p_wdata;
      if (p_ctrl_wr)
        ctrl_r <= p_wdata;
      if (p_stat_wr)
        stat_r <= p_wdata;
      if (p_ctrl2_wr)
        ctrl2_r <= p_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] rtc_view(input logic [7:0] a);
    case (a)
      RTCDP_OFS_SEC: return enc(sec_r, bin_mode);
      RTCDP_OFS_SEC_ALM: return sec_alm_r;
      RTCDP_OFS_MIN: return enc(min_r, bin_mode);
      RTCDP_OFS_MIN_ALM: return min_alm_r;
      RTCDP_OFS_HOUR: return hour_view;
      RTCDP_OFS_HOUR_ALM: return hour_alm_r;
      RTCDP_OFS_WDAY: return enc(wday_r, bin_mode);
      RTCDP_OFS_MDAY: return enc(mday_r, bin_mode);
      RTCDP_OFS_MONTH: return enc(month_r, bin_mode);
      RTCDP_OFS_YEAR: return enc(year_r, bin_mode);
      RTCDP_OFS_CTRL: return ctrl_r;
      RTCDP_OFS_STAT: return stat_r;
      RTCDP_OFS_CTRL2: return ctrl2_r;
      default: return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Backup memory
  // ----------------------------------------------------------------
  // memory owner
  wire p_mem_we = p_mem_wr & memory_write_owner_sel & ~p_addr[7];
  wire s_mem_we = s_mem_wr & ~memory_write_owner_sel & ~s_addr[7];
  wire [7:0] mem_wa = p_mem_we ? p_addr : s_addr;
  wire [7:0] mem_wd = p_mem_we ? p_wdata : s_wdata;
  logic [7:0] p_mem_q, s_mem_q;
  logic mem_busy;

  rtcdp_mem u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .clr_start(clr_rise),
    .wr_en(p_mem_we | s_mem_we),
    .wr_addr(mem_wa[RTCDP_MEM_AW-1:0]),
    .wr_data(mem_wd),
    .rd_addr_a(p_addr[RTCDP_MEM_AW-1:0]),
    .rd_addr_b(s_addr[RTCDP_MEM_AW-1:0]),
    .rd_data_a_r(p_mem_q),
    .rd_data_b_r(s_mem_q),
    .clr_busy_r(mem_busy)
  );

  // ----------------------------------------------------------------
  // Read pipelines, two cycles for both register kinds
  // ----------------------------------------------------------------
  logic p_rd_q_r, s_rd_q_r, p_sel_mem_r, s_sel_mem_r;
  logic [7:0] p_rtc_q_r, s_rtc_q_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      p_rd_q_r <= 1'b0;
      s_rd_q_r <= 1'b0;
      p_sel_mem_r <= 1'b0;
      s_sel_mem_r <= 1'b0;
      p_rtc_q_r <= 8'h00;
      s_rtc_q_r <= 8'h00;
      p_rdata_r <= 8'h00;
      s_rdata_r <= 8'h00;
      p_rvalid_r <= 1'b0;
      s_rvalid_r <= 1'b0;
      mem_clear_busy_r <= 1'b0;
    end
    else
    begin
      p_rd_q_r <= p_rtc_rd | p_mem_rd;
      s_rd_q_r <= s_rtc_rd | s_mem_rd;
      p_sel_mem_r <= p_mem_rd & ~p_addr[7];
      s_sel_mem_r <= s_mem_rd & ~s_addr[7];
      p_rtc_q_r <= p_rtc_rd ? rtc_view(p_addr) : 8'h00;
      s_rtc_q_r <= s_rtc_rd ? rtc_view(s_addr) : 8'h00;
      p_rdata_r <= p_sel_mem_r ? p_mem_q : p_rtc_q_r;
      s_rdata_r <= s_sel_mem_r ? s_mem_q : s_rtc_q_r;
      p_rvalid_r <= p_rd_q_r;
      s_rvalid_r <= s_rd_q_r;
      mem_clear_busy_r <= mem_busy;
    end
  end

endmodule

// ===== tb/rtcdp_properties.sv
// Purpose: Port-level assertions for the dual-port time and memory block.
// Assumes: Control bytes change only through primary-port writes.
// Notes:   Bound to every rtcdp_top instance.
`timescale 1ns/1ps
module rtcdp_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic one_hz_tick,
  input wire logic backup_clear_pin,
  input wire logic p_rtc_wr,
  input wire logic p_rtc_rd,
  input wire logic p_mem_wr,
  input wire logic p_mem_rd,
  input wire logic [7:0] p_addr,
  input wire logic [7:0] p_wdata,
  input wire logic [7:0] p_rdata_r,
  input wire logic p_rvalid_r,
  input wire logic s_rtc_wr,
  input wire logic s_rtc_rd,
  input wire logic s_mem_wr,
  input wire logic s_mem_rd,
  input wire logic [7:0] s_addr,
  input wire logic [7:0] s_wdata,
  input wire logic [7:0] s_rdata_r,
  input wire logic s_rvalid_r,
  input wire logic mem_clear_busy_r
);
  import rtcdp_pkg::*;
  logic [7:0] ctrl_sh_r;
  logic [7:0] ctrl2_sh_r;
  logic [7:0] busy_cnt_r;
  wire p_rd_any = p_rtc_rd | p_mem_rd;
  wire s_rd_any = s_rtc_rd | s_mem_rd;
  wire bin_mode = ctrl_sh_r[RTCDP_CTRL_DM_BIT];
  wire cnt_addr = p_addr inside {8'h00, 8'h02, 8'h07, 8'h08, 8'h09};
  wire lim_addr = p_addr inside {8'h00, 8'h02, 8'h09};
  wire [7:0] lim = (p_addr == RTCDP_OFS_YEAR) ? RTCDP_YEAR_MAX
                                               : RTCDP_SEC_MAX;

  // Shadow of the primary-only control bytes and clear sweep length.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl_sh_r <= RTCDP_RST_CTRL;
      ctrl2_sh_r <= RTCDP_RST_CTRL2;
      busy_cnt_r <= 8'h00;
    end
    else
    begin
      if (p_rtc_wr && p_addr == RTCDP_OFS_CTRL)
        ctrl_sh_r <= p_wdata;
      if (p_rtc_wr && p_addr == RTCDP_OFS_CTRL2)
        ctrl2_sh_r <= p_wdata;
      busy_cnt_r <= mem_clear_busy_r ? busy_cnt_r + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_rd_lat_p: assert property (p_rd_any |-> ##2 p_rvalid_r)
    else $error("primary read answer missing");
  a_rv_cause_s: assert property (s_rvalid_r |-> $past(s_rd_any, 2))
    else $error("secondary answer without read");
  a_clr_start: assert property ($rose(backup_clear_pin) |->
    ##[1:6] mem_clear_busy_r) else $error("clear sweep did not start");
  a_clr_len: assert property ($fell(mem_clear_busy_r) |->
    busy_cnt_r == 8'h80) else $error("clear sweep length wrong");
  a_mem_hi_zero: assert property (p_mem_rd && p_addr[7] |->
    ##2 p_rdata_r == 8'h00) else $error("memory above 7Fh not zero");
  a_bcd_digits: assert property (p_rtc_rd && cnt_addr && !bin_mode |->
    ##2 (p_rdata_r[7:4] <= 4'h9 && p_rdata_r[3:0] <= 4'h9))
    else $error("decimal digit out of range");
  a_bin_range: assert property (p_rtc_rd && lim_addr && bin_mode |->
    ##2 p_rdata_r <= $past(lim, 2)) else $error("binary count too big");
  a_ctrl_back: assert property (p_rtc_rd && p_addr == RTCDP_OFS_CTRL |->
    ##2 p_rdata_r == $past(ctrl_sh_r, 2)) else $error("control changed");
  a_ctrl2_back: assert property (s_rtc_rd &&
    s_addr == RTCDP_OFS_CTRL2 |-> ##2 s_rdata_r == $past(ctrl2_sh_r, 2))
    else $error("ctrl2 changed");

  c_p_read: cover property (p_rvalid_r);
  c_s_memwr: cover property (s_mem_wr);
  c_clr_done: cover property ($fell(mem_clear_busy_r));
endmodule

bind rtcdp_top rtcdp_properties i_rtcdp_properties (
  .clock(clock), .rst_n(rst_n), .one_hz_tick(one_hz_tick),
  .backup_clear_pin(backup_clear_pin), .p_rtc_wr(p_rtc_wr),
  .p_rtc_rd(p_rtc_rd), .p_mem_wr(p_mem_wr), .p_mem_rd(p_mem_rd),
  .p_addr(p_addr), .p_wdata(p_wdata), .p_rdata_r(p_rdata_r),
  .p_rvalid_r(p_rvalid_r), .s_rtc_wr(s_rtc_wr), .s_rtc_rd(s_rtc_rd),
  .s_mem_wr(s_mem_wr), .s_mem_rd(s_mem_rd), .s_addr(s_addr),
  .s_wdata(s_wdata), .s_rdata_r(s_rdata_r), .s_rvalid_r(s_rvalid_r),
  .mem_clear_busy_r(mem_clear_busy_r));

// ===== tb/rtcdp_host.sv
// Purpose: Host controller model issuing byte accesses on one port.
// Assumes: One strobe per access, launched at a falling edge.
// Notes:   Address and data are inverted when released.
`timescale 1ns/1ps
module rtcdp_host (
  input wire logic clock,
  output logic rtc_wr,
  output logic rtc_rd,
  output logic mem_wr,
  output logic mem_rd,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial
  begin
    {rtc_wr, rtc_rd, mem_wr, mem_rd} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // Kind 0 register write, 1 register read, 2 memory write, 3 memory read.
  task automatic access(input logic [1:0] k, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clock);
    {mem_rd, mem_wr, rtc_rd, rtc_wr} = 4'h1 << k;
    addr = a;
    wdata = d;
    @(negedge clock);
    {rtc_wr, rtc_rd, mem_wr, mem_rd} = 4'h0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule

// ===== tb/rtcdp_top_test.sv
// Purpose: Self-checking bench for the dual-port time and memory block.
// Assumes: Read expectations are queued in issue order per port.
// Notes:   Hours are set in 24-hour mode for the calendar cases.
`timescale 1ns/1ps
module rtcdp_top_test;
  import rtcdp_pkg::*;
  localparam logic [1:0] RW = 2'h0;
  localparam logic [1:0] RR = 2'h1;
  localparam logic [1:0] MW = 2'h2;
  localparam logic [1:0] MR = 2'h3;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic one_hz_tick = 1'b0;
  logic backup_clear_pin = 1'b0;
  logic p_rtc_wr, p_rtc_rd, p_mem_wr, p_mem_rd, p_rvalid_r;
  logic s_rtc_wr, s_rtc_rd, s_mem_wr, s_mem_rd, s_rvalid_r;
  logic [7:0] p_addr, p_wdata, p_rdata_r, s_addr, s_wdata, s_rdata_r;
  logic mem_clear_busy_r;
  logic [7:0] q_p[$];
  logic [7:0] q_s[$];
  logic [7:0] rnd;
  int fails = 0;
  int num_checks = 0;
  int seed = 32'h4F54;
  int n;
  logic [7:0] rst_vals [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h92, 8'h12,
    8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Year, month, day in; then expected day, month, year after one tick.
  logic [47:0] cal [3] = '{48'h04_02_28_29_02_04, 48'h05_02_28_01_03_05,
    48'h99_12_31_01_01_00};

  always #4 clock = ~clock;

  rtcdp_host i_host_p (.clock(clock), .rtc_wr(p_rtc_wr), .rtc_rd(p_rtc_rd),
    .mem_wr(p_mem_wr), .mem_rd(p_mem_rd), .addr(p_addr), .wdata(p_wdata));
  rtcdp_host i_host_s (.clock(clock), .rtc_wr(s_rtc_wr), .rtc_rd(s_rtc_rd),
    .mem_wr(s_mem_wr), .mem_rd(s_mem_rd), .addr(s_addr), .wdata(s_wdata));
  rtcdp_top i_rtcdp_top (.clock(clock), .rst_n(rst_n),
    .one_hz_tick(one_hz_tick), .backup_clear_pin(backup_clear_pin),
    .p_rtc_wr(p_rtc_wr), .p_rtc_rd(p_rtc_rd), .p_mem_wr(p_mem_wr),
    .p_mem_rd(p_mem_rd), .p_addr(p_addr), .p_wdata(p_wdata),
    .p_rdata_r(p_rdata_r), .p_rvalid_r(p_rvalid_r), .s_rtc_wr(s_rtc_wr),
    .s_rtc_rd(s_rtc_rd), .s_mem_wr(s_mem_wr), .s_mem_rd(s_mem_rd),
    .s_addr(s_addr), .s_wdata(s_wdata), .s_rdata_r(s_rdata_r),
    .s_rvalid_r(s_rvalid_r), .mem_clear_busy_r(mem_clear_busy_r));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask

  // A read passes its expected byte as d; it is queued for the watcher.
  task automatic acc(input bit sec, input logic [1:0] k,
                     input logic [7:0] a, input logic [7:0] d);
    if (k[0] && sec)
      q_s.push_back(d);
    else if (k[0])
      q_p.push_back(d);
    if (sec)
      i_host_s.access(k, a, d);
    else
      i_host_p.access(k, a, d);
  endtask

  task automatic tick();
    @(negedge clock);
    one_hz_tick = 1'b1;
    repeat (4) @(negedge clock);
    one_hz_tick = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic end_test(input string name);
    repeat (4) @(negedge clock);
    $display("test %s done", name);
  endtask

  task automatic wrap_up();
    fails += q_p.size() + q_s.size();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(negedge clock)
  begin
    if (p_rvalid_r === 1'b1)
      chk(p_rdata_r, q_p.size() ? q_p.pop_front() : ~p_rdata_r);
    if (s_rvalid_r === 1'b1)
      chk(s_rdata_r, q_s.size() ? q_s.pop_front() : ~s_rdata_r);
  end

  initial
  begin
    #400000;
    fails++;
    wrap_up();
  end

  initial
  begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    for (int i = 0; i < 14; i++)
      acc(0, RR, 8'(i), rst_vals[i]);
    end_test("reset values");
    acc(0, RW, RTCDP_OFS_SEC, 8'h30);
    acc(1, RW, RTCDP_OFS_SEC, 8'h45);
    acc(1, RW, RTCDP_OFS_CTRL, 8'h01);
    acc(1, RR, RTCDP_OFS_SEC, 8'h45);
    acc(0, RR, RTCDP_OFS_CTRL, 8'h00);
    acc(1, RW, RTCDP_OFS_STAT, 8'h5A);
    acc(0, RW, RTCDP_OFS_STAT, 8'hA5);
    acc(1, RR, RTCDP_OFS_STAT, 8'hA5);
    acc(0, RW, RTCDP_OFS_CTRL, 8'h01);
    acc(1, RW, RTCDP_OFS_SEC, 8'h11);
    acc(0, RR, RTCDP_OFS_SEC, 8'h45);
    acc(0, RW, RTCDP_OFS_SEC, 8'h59);
    acc(1, RR, RTCDP_OFS_SEC, 8'h59);
    acc(0, RW, RTCDP_OFS_CTRL, 8'h41);
    acc(0, RR, RTCDP_OFS_SEC, 8'h3B);
    acc(0, RW, RTCDP_OFS_YEAR, 8'h63);
    acc(0, RR, RTCDP_OFS_YEAR, 8'h63);
    acc(0, RW, RTCDP_OFS_CTRL, 8'h21);
    acc(0, RR, RTCDP_OFS_YEAR, 8'h99);
    end_test("ownership and modes");
    for (int i = 0; i < 3; i++)
    begin
      acc(0, RW, RTCDP_OFS_YEAR, cal[i][47:40]);
      acc(0, RW, RTCDP_OFS_MONTH, cal[i][39:32]);
      acc(0, RW, RTCDP_OFS_MDAY, cal[i][31:24]);
      acc(0, RW, RTCDP_OFS_HOUR, 8'h23);
      acc(0, RW, RTCDP_OFS_MIN, 8'h59);
      acc(0, RW, RTCDP_OFS_SEC, 8'h59);
      tick();
      acc(0, RR, RTCDP_OFS_SEC, 8'h00);
      acc(0, RR, RTCDP_OFS_HOUR, 8'h00);
      acc(0, RR, RTCDP_OFS_MDAY, cal[i][23:16]);
      acc(0, RR, RTCDP_OFS_MONTH, cal[i][15:8]);
      acc(1, RR, RTCDP_OFS_YEAR, cal[i][7:0]);
    end
    acc(0, RW, RTCDP_OFS_CTRL, 8'hA1);
    tick();
    acc(0, RR, RTCDP_OFS_SEC, 8'h00);
    acc(1, RR, RTCDP_OFS_WDAY, 8'h04);
    acc(0, RW, RTCDP_OFS_CTRL, 8'h01);
    acc(0, RW, RTCDP_OFS_HOUR, 8'h91);
    acc(1, RR, RTCDP_OFS_HOUR, 8'h91);
    end_test("calendar");
    rnd = 8'($random(seed));
    acc(1, MW, 8'h7F, rnd);
    acc(0, MW, 8'h7F, ~rnd);
    acc(1, RW, RTCDP_OFS_CTRL2, 8'h01);
    acc(0, MW, 8'h7F, ~rnd);
    acc(0, MR, 8'h7F, rnd);
    acc(0, MR, 8'h80, 8'h00);
    acc(0, RW, RTCDP_OFS_CTRL2, 8'h01);
    acc(1, RR, RTCDP_OFS_CTRL2, 8'h01);
    acc(0, MW, 8'h00, rnd);
    acc(1, MW, 8'h00, ~rnd);
    acc(1, MR, 8'h00, rnd);
    end_test("memory rights");
    backup_clear_pin = 1'b1;
    for (n = 0; n < 20 && mem_clear_busy_r !== 1'b1; n++)
      @(negedge clock);
    chk({7'h00, mem_clear_busy_r}, 8'h01);
    for (n = 0; n < 200 && mem_clear_busy_r !== 1'b0; n++)
      @(negedge clock);
    chk({7'h00, mem_clear_busy_r}, 8'h00);
    backup_clear_pin = 1'b0;
    acc(1, MR, 8'h7F, 8'h00);
    for (int i = 0; i < 4; i++)
      acc(0, MR, 8'($random(seed)) & 8'h7F, 8'h00);
    end_test("memory clear");
    wrap_up();
  end
endmodule
